// ### logic/ltc_pkg.sv
// constants and register map of the link-training coefficient override bank
package ltc_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] LTC_IDX_OVERRIDE   = 8'hd0;
    localparam logic [7:0] LTC_IDX_REQUEST    = 8'hd1;
    localparam logic [7:0] LTC_IDX_FL_STATUS  = 8'hd2;
    localparam logic [7:0] LTC_IDX_COEF_L1    = 8'he1;
    localparam logic [7:0] LTC_IDX_TSTAT_L1   = 8'he2;
    localparam logic [7:0] LTC_IDX_COEF_L2    = 8'he5;
    localparam logic [7:0] LTC_IDX_TSTAT_L2   = 8'he6;
    localparam logic [7:0] LTC_IDX_COEF_L3    = 8'he9;
    localparam logic [7:0] LTC_IDX_TSTAT_L3   = 8'hea;
    localparam logic [7:0] LTC_IDX_IRQ_STATUS = 8'hf0;
    localparam logic [7:0] LTC_IDX_IRQ_ENABLE = 8'hf1;
    localparam logic [7:0] LTC_IDX_IRQ_CLEAR  = 8'hf2;

    // override enable bit positions
    localparam int LTC_BIT_PARTNER_EN = 16;
    localparam int LTC_BIT_LOCAL_EN   = 17;

    // request bit positions, lane 1 at the base
    localparam int LTC_BIT_PARTNER_REQ = 5;
    localparam int LTC_BIT_LOCAL_REQ   = 9;

    // frame-lock status field base (lane 1), 8 bits per lane
    localparam int LTC_BIT_FL_ERR = 8;
    localparam int LTC_FL_W       = 8;

    // coefficient field positions inside a lane coefficient register
    localparam int LTC_BIT_PARTNER_COEF = 0;
    localparam int LTC_BIT_LOCAL_COEF   = 16;
    localparam int LTC_COEF_W           = 8;

    // interrupt status layout
    localparam int LTC_IRQ_PARTNER = 0;
    localparam int LTC_IRQ_LOCAL   = 3;
    localparam int LTC_IRQ_UNREC   = 6;
    localparam int LTC_IRQ_W       = 8;

    // reset values
    localparam logic [31:0] LTC_RST_WORD = 32'h0000_0000;
    localparam logic        LTC_RST_BIT  = 1'b0;

    // axi responses
    localparam logic [1:0] LTC_RESP_OKAY   = 2'b00;
    localparam logic [1:0] LTC_RESP_SLVERR = 2'b10;

endpackage

// ### logic/ltc_lane_req.sv
// one lane's self-clearing coefficient request pair
`timescale 1ns/1ns
`default_nettype none
module ltc_lane_req
    import ltc_pkg::*;
(
    input  wire logic sys_clk_i,        // register clock
    input  wire logic rst_b_i,          // sync reset, active low
    input  wire logic partner_wr_i,     // write of a 1 to partner request
    input  wire logic local_wr_i,       // write of a 1 to local request
    input  wire logic partner_en_i,     // partner override enable
    input  wire logic local_en_i,       // local override enable
    input  wire logic partner_ack_i,    // training logic took partner push
    input  wire logic local_ack_i,      // training logic took local apply
    output logic      partner_req_o,    // pending partner push
    output logic      local_req_o,      // pending local apply
    output logic      partner_taken_o,  // pulse: partner push taken
    output logic      local_taken_o     // pulse: local apply taken
);

    logic partner_q;  // partner push pending
    logic local_q;    // local apply pending

    // partner push: set only while enabled, cleared by the taker
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            partner_q <= LTC_RST_BIT;
        end else if (partner_wr_i && partner_en_i) begin
            partner_q <= 1'b1;
        end else if (partner_ack_i) begin
            partner_q <= 1'b0;
        end
    end

    // local apply: same scheme with the local enable
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            local_q <= LTC_RST_BIT;
        end else if (local_wr_i && local_en_i) begin
            local_q <= 1'b1;
        end else if (local_ack_i) begin
            local_q <= 1'b0;
        end
    end

    // handshake outputs; taken only counts a pending request
    assign partner_req_o   = partner_q;
    assign local_req_o     = local_q;
    assign partner_taken_o = partner_q && partner_ack_i;
    assign local_taken_o   = local_q && local_ack_i;

endmodule
`default_nettype wire

// ### logic/ltc_regs.sv
// link-training coefficient override register bank with axi4-lite slave
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module ltc_regs
    import ltc_pkg::*;
#(
    parameter int          ADDR_W   = 12,           // byte address width
    parameter int          TAP_W    = 32,           // training status width
    parameter logic [31:0] INIT_TAP = 32'h0000_0000 // initial tap settings
)(
    input  wire logic              sys_clk_i,      // register clock
    input  wire logic              rst_b_i,        // sync reset, active low
    // axi4-lite write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,   // write address
    input  wire logic              s_axi_awvalid,  // address valid
    output logic                   s_axi_awready,  // address ready
    // axi4-lite write data
    input  wire logic [31:0]       s_axi_wdata,    // write data
    input  wire logic [3:0]        s_axi_wstrb,    // byte enables
    input  wire logic              s_axi_wvalid,   // data valid
    output logic                   s_axi_wready,   // data ready
    // axi4-lite write response
    output logic [1:0]             s_axi_bresp,    // write response
    output logic                   s_axi_bvalid,   // response valid
    input  wire logic              s_axi_bready,   // response ready
    // axi4-lite read address
    input  wire logic [ADDR_W-1:0] s_axi_araddr,   // read address
    input  wire logic              s_axi_arvalid,  // address valid
    output logic                   s_axi_arready,  // address ready
    // axi4-lite read data
    output logic [31:0]            s_axi_rdata,    // read data
    output logic [1:0]             s_axi_rresp,    // read response
    output logic                   s_axi_rvalid,   // data valid
    input  wire logic              s_axi_rready,   // data ready
    // toward the link-training logic, lane 1 in bit 0
    output logic [2:0]             partner_coef_req_o,  // push request
    input  wire logic [2:0]        partner_coef_ack_i,  // push taken
    output logic [23:0]            partner_coef_o,      // partner coefs
    output logic [2:0]             local_coef_req_o,    // apply request
    input  wire logic [2:0]        local_coef_ack_i,    // apply taken
    output logic [23:0]            local_coef_o,        // local coefs
    // from the link-training logic; frame-lock errors for lanes 1 and 2, tap settings for lanes 1 to 3
    input  wire logic [15:0]       frame_lock_err_i,    // frame-lock errors
    input  wire logic [3*TAP_W-1:0] tap_status_i,       // tap settings
    output logic [1:0]             fl_unrecoverable_o,  // unrecoverable
    output logic                   irq_o                // interrupt level
);

    // ---------------- axi4-lite slave ----------------
    logic              aw_held_q;   // write address captured
    logic [ADDR_W-1:0] aw_addr_q;   // captured write address
    logic              w_held_q;    // write data captured
    logic [31:0]       w_data_q;    // captured write data
    logic [3:0]        w_strb_q;    // captured byte enables
    logic              bvalid_q;    // write response pending
    logic [1:0]        bresp_q;     // write response code
    logic              rvalid_q;    // read data pending
    logic [31:0]       rdata_q;     // read data word
    logic [1:0]        rresp_q;     // read response code
    logic              do_write;    // both halves present, commit now
    logic [7:0]        wr_idx;      // write register index
    logic [7:0]        rd_idx;      // read register index
    logic              wr_hit;      // write index is mapped
    logic [31:0]       rd_word;     // read mux output
    logic              rd_hit;      // read index is mapped

    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready  = !w_held_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign do_write      = aw_held_q && w_held_q && !bvalid_q;
    assign wr_idx        = aw_addr_q[9:2];
    assign rd_idx        = s_axi_araddr[9:2];

    // write address capture, independent of write data
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_q <= 1'b0;
        end
    end

    // write data capture
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            w_held_q <= 1'b0;
            w_data_q <= LTC_RST_WORD;
            w_strb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (do_write) begin
            w_held_q <= 1'b0;
        end
    end

    // write response, slverr for an unmapped index
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            bvalid_q <= 1'b0;
            bresp_q  <= LTC_RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? LTC_RESP_OKAY : LTC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // read data, registered on the address handshake
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            rvalid_q <= 1'b0;
            rdata_q  <= LTC_RST_WORD;
            rresp_q  <= LTC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_word;
            rresp_q  <= rd_hit ? LTC_RESP_OKAY : LTC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // byte-lane merge of a write into an old word
    function automatic logic [31:0] merge(input logic [31:0] old_w,
                                          input logic [31:0] new_w,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = new_w[8*b +: 8];
            end
        end
        return res;
    endfunction

    // ---------------- control registers ----------------
    logic              partner_en_q;  // partner override enable
    logic              local_en_q;    // local override enable
    logic [31:0]       coef_q [3];    // per-lane coefficient words
    logic [LTC_IRQ_W-1:0] irq_stat_q; // sticky event bits
    logic [LTC_IRQ_W-1:0] irq_en_q;   // event enables
    logic [LTC_IRQ_W-1:0] irq_evt;    // this cycle's events
    logic [LTC_IRQ_W-1:0] irq_clr;    // this cycle's clears
    logic [31:0]       merged;        // write data merged onto zero
    logic              req_wr;        // write to the request register

    assign merged = merge(LTC_RST_WORD, w_data_q, w_strb_q);
    assign req_wr = do_write && (wr_idx == LTC_IDX_REQUEST);

    // override enables; only the byte holding them is written
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            partner_en_q <= LTC_RST_BIT;
            local_en_q   <= LTC_RST_BIT;
        end else if (do_write && wr_idx == LTC_IDX_OVERRIDE && w_strb_q[2]) begin
            partner_en_q <= w_data_q[LTC_BIT_PARTNER_EN];
            local_en_q   <= w_data_q[LTC_BIT_LOCAL_EN];
        end
    end

    // per-lane request logic and coefficient words
    logic [7:0] coef_idx [3];     // coefficient register index per lane
    logic [2:0] partner_taken;    // push taken pulses
    logic [2:0] local_taken;      // apply taken pulses

    assign coef_idx[0] = LTC_IDX_COEF_L1;
    assign coef_idx[1] = LTC_IDX_COEF_L2;
    assign coef_idx[2] = LTC_IDX_COEF_L3;

    for (genvar l = 0; l < 3; l++) begin : g_lane
        // coefficient word, byte-lane writable
        always_ff @(posedge sys_clk_i) begin
            if (!rst_b_i) begin
                coef_q[l] <= LTC_RST_WORD;
            end else if (do_write && wr_idx == coef_idx[l]) begin
                coef_q[l] <= merge(coef_q[l], w_data_q, w_strb_q);
            end
        end

        // coefficient fields presented to the training logic
        assign partner_coef_o[8*l +: 8] =
            coef_q[l][LTC_BIT_PARTNER_COEF +: LTC_COEF_W];
        assign local_coef_o[8*l +: 8] =
            coef_q[l][LTC_BIT_LOCAL_COEF +: LTC_COEF_W];

        // request pair; bit positions step by lane
        ltc_lane_req u_req (
            .sys_clk_i       (sys_clk_i),
            .rst_b_i         (rst_b_i),
            .partner_wr_i    (req_wr && merged[LTC_BIT_PARTNER_REQ + l]),
            .local_wr_i      (req_wr && merged[LTC_BIT_LOCAL_REQ + l]),
            .partner_en_i    (partner_en_q),
            .local_en_i      (local_en_q),
            .partner_ack_i   (partner_coef_ack_i[l]),
            .local_ack_i     (local_coef_ack_i[l]),
            .partner_req_o   (partner_coef_req_o[l]),
            .local_req_o     (local_coef_req_o[l]),
            .partner_taken_o (partner_taken[l]),
            .local_taken_o   (local_taken[l])
        );
    end

    // ---------------- frame-lock status ----------------
    logic [15:0] fl_err_q;    // sampled frame-lock errors, lanes 1-2
    logic [1:0]  unrec_q;     // unrecoverable flags, lanes 1-2
    logic [1:0]  unrec_rise;  // new unrecoverable condition

    // sample error fields for the read path
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            fl_err_q <= 16'h0000;
        end else begin
            fl_err_q <= frame_lock_err_i;
        end
    end

    for (genvar u = 0; u < 2; u++) begin : g_unrec
        // error present while the taps still equal their start values
        always_ff @(posedge sys_clk_i) begin
            if (!rst_b_i) begin
                unrec_q[u] <= 1'b0;
            end else begin
                unrec_q[u] <= (|fl_err_q[8*u +: 8]) &&
                    (tap_status_i[TAP_W*u +: TAP_W] == INIT_TAP[TAP_W-1:0]);
            end
        end
        assign unrec_rise[u] = (|fl_err_q[8*u +: 8]) &&
            (tap_status_i[TAP_W*u +: TAP_W] == INIT_TAP[TAP_W-1:0]) &&
            !unrec_q[u];
    end

    assign fl_unrecoverable_o = unrec_q;

    // ---------------- interrupts ----------------
    assign irq_evt = {unrec_rise, local_taken, partner_taken};
    assign irq_clr = (do_write && wr_idx == LTC_IDX_IRQ_CLEAR)
                   ? merged[LTC_IRQ_W-1:0] : '0;

    // sticky status: a new event wins over a clear in the same cycle
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
        end
    end

    // interrupt enables
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            irq_en_q <= '0;
        end else if (do_write && wr_idx == LTC_IDX_IRQ_ENABLE && w_strb_q[0]) begin
            irq_en_q <= w_data_q[LTC_IRQ_W-1:0];
        end
    end

    // interrupt level
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(((irq_stat_q & ~irq_clr) | irq_evt) & irq_en_q);
        end
    end

    // ---------------- decode ----------------
    // mapped write indices
    always_comb begin
        case (wr_idx)
            LTC_IDX_OVERRIDE, LTC_IDX_REQUEST, LTC_IDX_FL_STATUS,
            LTC_IDX_COEF_L1, LTC_IDX_COEF_L2, LTC_IDX_COEF_L3,
            LTC_IDX_TSTAT_L1, LTC_IDX_TSTAT_L2, LTC_IDX_TSTAT_L3,
            LTC_IDX_IRQ_STATUS, LTC_IDX_IRQ_ENABLE,
            LTC_IDX_IRQ_CLEAR: wr_hit = 1'b1;
            default:           wr_hit = 1'b0;
        endcase
    end

    // read mux; unused bits read as zero
    always_comb begin
        rd_word = LTC_RST_WORD;
        rd_hit  = 1'b1;
        case (rd_idx)
            LTC_IDX_OVERRIDE: begin
                rd_word[LTC_BIT_PARTNER_EN] = partner_en_q;
                rd_word[LTC_BIT_LOCAL_EN]   = local_en_q;
            end
            LTC_IDX_REQUEST: begin
                rd_word[LTC_BIT_PARTNER_REQ +: 3] = partner_coef_req_o;
                rd_word[LTC_BIT_LOCAL_REQ +: 3]   = local_coef_req_o;
            end
            LTC_IDX_FL_STATUS: begin
                rd_word[LTC_BIT_FL_ERR +: 2*LTC_FL_W] = fl_err_q;
            end
            LTC_IDX_COEF_L1:    rd_word = coef_q[0];
            LTC_IDX_COEF_L2:    rd_word = coef_q[1];
            LTC_IDX_COEF_L3:    rd_word = coef_q[2];
            LTC_IDX_TSTAT_L1:   rd_word[TAP_W-1:0] = tap_status_i[0 +: TAP_W];
            LTC_IDX_TSTAT_L2:   rd_word[TAP_W-1:0] = tap_status_i[TAP_W +: TAP_W];
            LTC_IDX_TSTAT_L3:   rd_word[TAP_W-1:0] = tap_status_i[2*TAP_W +: TAP_W];
            LTC_IDX_IRQ_STATUS: rd_word[LTC_IRQ_W-1:0] = irq_stat_q;
            LTC_IDX_IRQ_ENABLE: rd_word[LTC_IRQ_W-1:0] = irq_en_q;
            LTC_IDX_IRQ_CLEAR:  rd_word = LTC_RST_WORD;
            default:            rd_hit = 1'b0;
        endcase
    end

endmodule
`default_nettype wire

// ### dv/ltc_regs_monitor.sv
// assertion checker bound to the coefficient override register bank
`timescale 1ns/1ns
`default_nettype none
module ltc_regs_monitor
    import ltc_pkg::*;
#(
    parameter int          TAP_W    = 32,
    parameter logic [31:0] INIT_TAP = 32'h0000_0000
)(
    input wire logic               sys_clk_i,
    input wire logic               rst_b_i,
    input wire logic               s_axi_bvalid,
    input wire logic               s_axi_bready,
    input wire logic [1:0]         s_axi_bresp,
    input wire logic               s_axi_rvalid,
    input wire logic               s_axi_rready,
    input wire logic [31:0]        s_axi_rdata,
    input wire logic [2:0]         partner_coef_req_o,
    input wire logic [2:0]         partner_coef_ack_i,
    input wire logic [2:0]         local_coef_req_o,
    input wire logic [2:0]         local_coef_ack_i,
    input wire logic [15:0]        frame_lock_err_i,
    input wire logic [3*TAP_W-1:0] tap_status_i,
    input wire logic [1:0]         fl_unrecoverable_o
);
    logic u1; // lane 1 error with taps still at start values
    logic u2; // same for lane 2
    assign u1 = |frame_lock_err_i[7:0] && tap_status_i[31:0] == INIT_TAP;
    assign u2 = |frame_lock_err_i[15:8] && tap_status_i[63:32] == INIT_TAP;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    a_preq_hold: assert property (($past(partner_coef_req_o &
        ~partner_coef_ack_i) & ~partner_coef_req_o) == 3'h0)
        else $error("partner request lost without ack");
    a_lreq_hold: assert property (($past(local_coef_req_o &
        ~local_coef_ack_i) & ~local_coef_req_o) == 3'h0)
        else $error("local request lost without ack");
    a_preq_clear: assert property (($past(partner_coef_req_o &
        partner_coef_ack_i) & partner_coef_req_o) == 3'h0 ||
        $rose(s_axi_bvalid)) else $error("partner request not cleared");
    a_preq_cause: assert property ((partner_coef_req_o &
        ~$past(partner_coef_req_o)) == 3'h0 || $rose(s_axi_bvalid))
        else $error("partner request without write");
    a_lreq_cause: assert property ((local_coef_req_o &
        ~$past(local_coef_req_o)) == 3'h0 || $rose(s_axi_bvalid))
        else $error("local request without write");
    a_unrec_set: assert property (u1 [*3] |=>
        fl_unrecoverable_o[0]) else $error("lane 1 not unrecoverable");
    a_unrec_clr: assert property (!u2 [*3] |=>
        !fl_unrecoverable_o[1]) else $error("lane 2 wrongly unrecoverable");
endmodule
bind ltc_regs ltc_regs_monitor #(.TAP_W(TAP_W), .INIT_TAP(INIT_TAP)) u_mon (.*);
`default_nettype wire

// ### dv/ltc_train_model.sv
// behavioural link-training logic that takes coefficient requests
`timescale 1ns/1ns
`default_nettype none
module ltc_train_model
    import ltc_pkg::*;
(
    input  wire logic        sys_clk_i, // register clock
    input  wire logic        rst_b_i,   // sync reset, active low
    input  wire logic        slow_i,    // answer after a long wait
    input  wire logic [2:0]  p_req_i,   // pending partner pushes
    input  wire logic [2:0]  l_req_i,   // pending local applies
    input  wire logic [23:0] p_coef_i,  // partner coefs per lane
    input  wire logic [23:0] l_coef_i,  // local coefs per lane
    output logic      [2:0]  p_ack_o,   // partner push taken
    output logic      [2:0]  l_ack_o,   // local apply taken
    output logic      [23:0] p_got_o,   // last partner coefs sent
    output logic      [23:0] l_got_o    // last local coefs loaded
);
    logic [3:0] wait_q; // cycles a request has waited
    logic       go;     // time to answer
    assign go = wait_q >= {slow_i, 3'h0};
    // wait counter runs while anything is pending
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i || !(|{p_req_i, l_req_i}) || go) begin
            wait_q <= 4'h0;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
    end
    // one-cycle acknowledge of every pending request
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            p_ack_o <= 3'h0;
            l_ack_o <= 3'h0;
        end else begin
            p_ack_o <= go ? p_req_i & ~p_ack_o : 3'h0;
            l_ack_o <= go ? l_req_i & ~l_ack_o : 3'h0;
        end
    end
    // keep what each lane sent or loaded when taken
    always_ff @(posedge sys_clk_i) begin
        for (int n = 0; n < 3; n++) begin
            if (p_ack_o[n] && p_req_i[n]) begin
                p_got_o[8*n +: 8] <= p_coef_i[8*n +: 8];
            end
            if (l_ack_o[n] && l_req_i[n]) begin
                l_got_o[8*n +: 8] <= l_coef_i[8*n +: 8];
            end
        end
    end
endmodule
`default_nettype wire

// ### dv/ltc_tb.sv
// self-checking bench for the coefficient override register bank
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import ltc_pkg::*;
    typedef struct packed {
        logic [7:0] ix; logic w; logic [31:0] wd; logic [31:0] rx;
        logic [1:0] rs;
    } ltc_row_type;
    ltc_row_type rows [8]; // register access cases
    logic sys_clk_i = 1'b0, rst_b_i = 1'b0, slow = 1'b0;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid;
    logic arready, rvalid, irq;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [1:0] bresp, rresp, rs, unrec;
    logic [2:0] preq, pack, lreq, lack;
    logic [23:0] pcoef, lcoef, pgot, lgot;
    logic [15:0] fle = 16'h0;
    logic [95:0] tap = 96'h0;
    int n_fail = 0, n_checks = 0, cyc = 0;
    always #5 sys_clk_i = ~sys_clk_i;
    ltc_regs dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .partner_coef_req_o(preq), .partner_coef_ack_i(pack),
        .partner_coef_o(pcoef), .local_coef_req_o(lreq),
        .local_coef_ack_i(lack), .local_coef_o(lcoef),
        .frame_lock_err_i(fle), .tap_status_i(tap),
        .fl_unrecoverable_o(unrec), .irq_o(irq));
    ltc_train_model u_lt (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .slow_i(slow), .p_req_i(preq), .l_req_i(lreq), .p_coef_i(pcoef),
        .l_coef_i(lcoef), .p_ack_o(pack), .l_ack_o(lack), .p_got_o(pgot),
        .l_got_o(lgot));
    // axi write: address and data together; slow holds bready back
    task automatic wr(input logic [7:0] ix, input logic [31:0] v);
        logic a = 1'b0, w = 1'b0;
        @(posedge sys_clk_i);
        awaddr <= {2'b00, ix, 2'b00}; wdata <= v;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= !slow;
        while (!(a && w)) begin
            @(posedge sys_clk_i);
            if (!a && awready) begin a = 1'b1; awvalid <= 1'b0; end
            if (!w && wready) begin w = 1'b1; wvalid <= 1'b0; end
        end
        while (!bvalid) @(posedge sys_clk_i);
        if (!bready) begin bready <= 1'b1; @(posedge sys_clk_i); end
        rs = bresp; bready <= 1'b0;
    endtask
    // axi read: returns data and response
    task automatic rd(input logic [7:0] ix);
        @(posedge sys_clk_i);
        araddr <= {2'b00, ix, 2'b00}; arvalid <= 1'b1; rready <= !slow;
        do @(posedge sys_clk_i); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge sys_clk_i);
        if (!rready) begin rready <= 1'b1; @(posedge sys_clk_i); end
        d = rdata; rs = rresp; rready <= 1'b0;
    endtask
    task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            n_fail++; $display("mismatch %0t reg %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_port(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            n_fail++; $display("mismatch %0t port %h exp %h", $time, g, e);
        end
    endtask
    task automatic final_report;
        if (n_fail == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // hang guard
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 20000) begin n_fail++; final_report(); end
    end
    initial begin
        rows = '{'{8'hd0, 1'b0, 32'h0, 32'h0, 2'b00},
            '{8'hd1, 1'b0, 32'h0, 32'h0, 2'b00},
            '{8'hd2, 1'b0, 32'h0, 32'h0, 2'b00},
            '{8'he1, 1'b1, 32'h00a5_00c3, 32'h00a5_00c3, 2'b00},
            '{8'he5, 1'b1, 32'h0011_0022, 32'h0011_0022, 2'b00},
            '{8'he9, 1'b1, 32'h0033_0044, 32'h0033_0044, 2'b00},
            '{8'hd1, 1'b1, 32'h0000_0ee0, 32'h0, 2'b00},
            '{8'h40, 1'b1, 32'hffff_ffff, 32'h0, LTC_RESP_SLVERR}};
        repeat (8) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w) begin
                wr(rows[i].ix, rows[i].wd);
                chk_reg(32'(rs), 32'(rows[i].rs));
            end
            rd(rows[i].ix);
            chk_reg(d, rows[i].rx);
            chk_reg(32'(rs), 32'(rows[i].rs));
        end
        // enabling later must not revive dropped requests
        wr(LTC_IDX_OVERRIDE, 32'h0003_0000);
        repeat (3) @(posedge sys_clk_i);
        chk_port(32'({lreq, preq}), 32'h0);
        wr(LTC_IDX_REQUEST, 32'h0000_0020);
        repeat (10) @(posedge sys_clk_i);
        chk_port(32'(pgot[7:0]), 32'h0000_00c3);
        chk_port(32'(preq), 32'h0);
        // slow training logic keeps requests pending
        slow <= 1'b1;
        wr(LTC_IDX_REQUEST, 32'h0000_0ec0);
        rd(LTC_IDX_REQUEST);
        chk_reg(d, 32'h0000_0ec0);
        chk_port(32'(preq), 32'h6);
        chk_port(32'(lreq), 32'h7);
        chk_port(32'(lcoef), 32'h0033_11a5);
        repeat (30) @(posedge sys_clk_i);
        rd(LTC_IDX_REQUEST);
        chk_reg(d, 32'h0);
        chk_port(32'(lgot), 32'h0033_11a5);
        chk_port(32'(pgot), 32'h0044_22c3);
        // interrupt: sticky, masked, enabled, cleared
        rd(LTC_IDX_IRQ_STATUS);
        chk_reg(d, 32'h0000_003f);
        chk_port(32'(irq), 32'h0);
        wr(LTC_IDX_IRQ_ENABLE, 32'h0000_0001);
        repeat (2) @(posedge sys_clk_i);
        chk_port(32'(irq), 32'h1);
        wr(LTC_IDX_IRQ_CLEAR, 32'h0000_003f);
        repeat (2) @(posedge sys_clk_i);
        chk_port(32'(irq), 32'h0);
        // frame-lock fields and unrecoverable lane 1
        fle <= 16'h5a3c;
        tap <= 96'h0000_0000_0000_0001_0000_0000;
        repeat (4) @(posedge sys_clk_i);
        rd(LTC_IDX_FL_STATUS);
        chk_reg(d, 32'h005a_3c00);
        chk_port(32'(unrec), 32'h1);
        // local apply with its enable off is ignored
        wr(LTC_IDX_OVERRIDE, 32'h0001_0000);
        wr(LTC_IDX_REQUEST, 32'h0000_0e00);
        chk_port(32'(lreq), 32'h0);
        rd(LTC_IDX_REQUEST);
        chk_reg(d, 32'h0);
        // reset in mid-run
        rst_b_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        rd(LTC_IDX_COEF_L1);
        chk_reg(d, 32'h0);
        final_report();
    end
endmodule
`default_nettype wire
